// File: hdl/uart_data_buffer.sv
/*
 * Serial transceiver data path behind an AXI4-Lite slave: one-deep
 * transmit holding buffer and shift register, two-entry receive queue,
 * baud generation, sticky interrupt status with mask.
 * Assumes serial_in is asynchronous; everything else is on aclk.
 */
// Decided for this implementation: the address map and register access over AXI4-Lite.
// Operation
// - One data location: writes fill transmit buffer, reads return receive buffer.
// - Sizes 5 to 7: unused upper bits ignored on send, zero on receive.
// - Data write accepted only while transmit buffer empty flag set; else dropped.
// - Enabled transmitter moves waiting byte into empty shift register, shifts out.
// - Receive buffer is a first-in first-out queue of two characters.
// - A data location read with the queue not empty pops the oldest received character.
// - Transmit buffer empty flag is set after reset.
// - Receive complete flag shows unread data; disabling receiver flushes queue.
// - Double speed select changes oversampling divisor from 16 to 8.
`timescale 1ns/1ps
module uart_data_buffer
    import uart_pkg::*;
(
    input wire logic aclk,                 // System clock, 250 MHz
    input wire logic aresetn,              // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr,  // Write address
    input wire logic awvalid,              // Write address valid
    output logic awready,                  // Write address ready
    input wire logic [31:0] wdata,         // Write data
    input wire logic [3:0] wstrb,          // Write byte strobes
    input wire logic wvalid,               // Write data valid
    output logic wready,                   // Write data ready
    output logic [1:0] bresp,              // Write response
    output logic bvalid,                   // Write response valid
    input wire logic bready,               // Write response ready
    input wire logic [ADDR_W-1:0] araddr,  // Read address
    input wire logic arvalid,              // Read address valid
    output logic arready,                  // Read address ready
    output logic [31:0] rdata,             // Read data
    output logic [1:0] rresp,              // Read response
    output logic rvalid,                   // Read data valid
    input wire logic rready,               // Read data ready
    input wire logic serial_in,            // Serial receive line
    output logic serial_out_pin,           // Serial transmit line
    output logic irq                       // Interrupt, active high level
);
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    baud_if bif ();
    uart_baud i_uart_baud (.aclk(aclk), .aresetn(aresetn), .bus(bif));

    logic [7:0] ctrl_q;
    logic [11:0] baud_q;
    logic [3:0] irq_mask_q, irq_stat_q, irq_stat_d, ev;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [31:0] wr_data_q;
    logic [3:0] wr_strb_q;
    logic aw_have_q, w_have_q, aw_have_d, w_have_d, bvalid_d, rvalid_d;
    logic do_wr, ar_hs, wr_ok, rd_ok;
    logic [31:0] rd_value;
    logic [3:0] n_bits;
    logic [8:0] size_mask;
    logic [4:0] spb;
    tx_state_t tx_state_q;
    logic [8:0] tx_hold_q;
    logic tx_empty_q;
    logic [10:0] tx_sh_q, frame;
    logic [3:0] tx_left_q;
    logic [4:0] tx_cnt_q;
    logic data_wr, accept, tx_load, tx_last;
    logic rx_meta_q, rx_line_q;
    rx_state_t rx_state_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_idx_q;
    logic [4:0] rx_cnt_q;
    logic rx_push, push_ok, pop, rx_en;
    logic [9:0] mem_q [0:1];
    logic wr_ptr_q, rd_ptr_q;
    logic [1:0] count_q;

    // ------------------------------------------------------------
    // Character size and bit timing
    // ------------------------------------------------------------
    always_comb begin
        case (ctrl_q[CTRL_SIZE_LSB +: 3])
            3'h0: n_bits = 4'h5;
            3'h1: n_bits = 4'h6;
            3'h2: n_bits = 4'h7;
            SIZE_9: n_bits = 4'h9;
            default: n_bits = 4'h8;
        endcase
        size_mask = 9'((10'h001 << n_bits) - 10'h001);
        spb = ctrl_q[CTRL_DOUBLE] ? SPB_DOUBLE : SPB_NORMAL;
    end
    assign bif.divider = baud_q;
    assign rx_en = ctrl_q[CTRL_RX_EN];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign do_wr = aw_have_q && w_have_q && !bvalid;
    assign aw_have_d = (aw_have_q || (awvalid && awready)) && !do_wr;
    assign w_have_d = (w_have_q || (wvalid && wready)) && !do_wr;
    assign bvalid_d = do_wr || (bvalid && !bready);
    assign ar_hs = arvalid && arready;
    assign rvalid_d = ar_hs || (rvalid && !rready);
    assign wr_ok = wr_addr_q inside {OFF_DATA, OFF_CTRL, OFF_STATUS, OFF_BAUD,
                                     OFF_IRQ_STAT, OFF_IRQ_MASK};
    assign rd_ok = araddr inside {OFF_DATA, OFF_CTRL, OFF_STATUS, OFF_BAUD,
                                  OFF_IRQ_STAT, OFF_IRQ_MASK};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_addr_q <= '0;
            wr_data_q <= 32'h0000_0000;
            wr_strb_q <= 4'h0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awready <= !aw_have_d && !bvalid_d;
            wready <= !w_have_d && !bvalid_d;
            bvalid <= bvalid_d;
            if (awvalid && awready) begin
                wr_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wr_data_q <= wdata;
                wr_strb_q <= wstrb;
            end
            if (do_wr) begin
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_comb begin
        case (araddr)
            OFF_DATA: rd_value = {23'h0, mem_q[rd_ptr_q][8:0]};
            OFF_CTRL: rd_value = {24'h0, ctrl_q};
            OFF_STATUS: rd_value = {27'h0, mem_q[rd_ptr_q][9] && count_q != 2'h0,
                                    mem_q[rd_ptr_q][8], tx_empty_q && tx_state_q == TX_IDLE,
                                    tx_empty_q, count_q != 2'h0};
            OFF_BAUD: rd_value = {20'h0, baud_q};
            OFF_IRQ_STAT: rd_value = {28'h0, irq_stat_q};
            OFF_IRQ_MASK: rd_value = {28'h0, irq_mask_q};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= !rvalid_d;
            rvalid <= rvalid_d;
            if (ar_hs) begin
                rdata <= rd_value;
                rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RESET;
            baud_q <= BAUD_RESET;
            irq_mask_q <= IRQ_RESET;
        end else if (do_wr) begin
            if (wr_addr_q == OFF_CTRL && wr_strb_q[0]) begin
                ctrl_q <= wr_data_q[7:0];
            end
            if (wr_addr_q == OFF_BAUD && wr_strb_q[0]) begin
                baud_q[7:0] <= wr_data_q[7:0];
            end
            if (wr_addr_q == OFF_BAUD && wr_strb_q[1]) begin
                baud_q[11:8] <= wr_data_q[11:8];
            end
            if (wr_addr_q == OFF_IRQ_MASK && wr_strb_q[0]) begin
                irq_mask_q <= wr_data_q[EV_W-1:0];
            end
        end
    end

    assign ev = {rx_push && !push_ok, tx_last, tx_load, push_ok};
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (do_wr && wr_addr_q == OFF_IRQ_STAT && wr_strb_q[0]) begin
            irq_stat_d = irq_stat_q & ~wr_data_q[EV_W-1:0];
        end
        irq_stat_d = irq_stat_d | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    assign data_wr = do_wr && wr_addr_q == OFF_DATA && wr_strb_q[0];
    assign accept = data_wr && tx_empty_q;
    assign tx_load = tx_state_q == TX_IDLE && ctrl_q[CTRL_TX_EN] && !tx_empty_q;
    assign tx_last = tx_state_q == TX_SHIFT && bif.tick && tx_cnt_q == spb - 5'h01
                     && tx_left_q == 4'h1;

    always_comb begin
        frame = 11'h7ff;
        frame[0] = 1'b0;
        frame[9:1] = tx_hold_q | ~size_mask;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_empty_q <= 1'b1;
            tx_hold_q <= 9'h000;
        end else if (accept) begin
            tx_empty_q <= 1'b0;
            tx_hold_q <= {ctrl_q[CTRL_TX_NINTH], wr_data_q[7:0]} & size_mask;
        end else if (tx_load) begin
            tx_empty_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q <= 11'h7ff;
            tx_left_q <= 4'h0;
            tx_cnt_q <= 5'h00;
            serial_out_pin <= 1'b1;
        end else begin
            serial_out_pin <= (tx_state_q == TX_SHIFT) ? tx_sh_q[0] : 1'b1;
            case (tx_state_q)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_q <= frame;
                        tx_left_q <= n_bits + 4'h2;
                        tx_cnt_q <= 5'h00;
                        tx_state_q <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (bif.tick) begin
                        if (tx_cnt_q == spb - 5'h01) begin
                            tx_cnt_q <= 5'h00;
                            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            tx_left_q <= tx_left_q - 4'h1;
                            if (tx_left_q == 4'h1) begin
                                tx_state_q <= TX_IDLE;
                            end
                        end else begin
                            tx_cnt_q <= tx_cnt_q + 5'h01;
                        end
                    end
                end
                default: tx_state_q <= TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta_q <= 1'b1;
            rx_line_q <= 1'b1;
        end else begin
            rx_meta_q <= serial_in;
            rx_line_q <= rx_meta_q;
        end
    end

    assign rx_push = rx_en && rx_state_q == RX_STOP && bif.tick && rx_cnt_q == spb - 5'h01;

    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_en) begin
            rx_state_q <= RX_IDLE;
            rx_sh_q <= 9'h000;
            rx_idx_q <= 4'h0;
            rx_cnt_q <= 5'h00;
        end else if (bif.tick) begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
            case (rx_state_q)
                RX_IDLE: begin
                    rx_cnt_q <= 5'h00;
                    if (!rx_line_q) begin
                        rx_state_q <= RX_START;
                        rx_sh_q <= 9'h000;
                        rx_idx_q <= 4'h0;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q == (spb >> 1) - 5'h01) begin
                        rx_cnt_q <= 5'h00;
                        rx_state_q <= rx_line_q ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_q == spb - 5'h01) begin
                        rx_cnt_q <= 5'h00;
                        rx_sh_q[rx_idx_q] <= rx_line_q;
                        rx_idx_q <= rx_idx_q + 4'h1;
                        if (rx_idx_q == n_bits - 4'h1) begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_q == spb - 5'h01) begin
                        rx_state_q <= RX_IDLE;
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Two-entry receive queue
    // ------------------------------------------------------------
    assign push_ok = rx_push && count_q != RX_DEPTH;
    assign pop = ar_hs && araddr == OFF_DATA && count_q != 2'h0;

    for (genvar g = 0; g < 2; g++) begin : g_entry
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mem_q[g] <= 10'h000;
            end else if (push_ok && wr_ptr_q == 1'(g)) begin
                mem_q[g] <= {!rx_line_q, rx_sh_q};
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_en) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push_ok) begin
                wr_ptr_q <= !wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push_ok} - {1'b0, pop};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_empty;
        $rose(aresetn) |-> tx_empty_q;
    endproperty
    a_reset_empty: assert property (p_reset_empty) else $error("tx empty not set after reset");

    property p_write_taken;
        accept |=> !tx_empty_q
                   && tx_hold_q[7:0] == ($past(wr_data_q[7:0]) & $past(size_mask[7:0]));
    endproperty
    a_write_taken: assert property (p_write_taken) else $error("data write not stored");

    property p_write_dropped;
        (data_wr && !tx_empty_q) |=> $stable(tx_hold_q);
    endproperty
    a_write_dropped: assert property (p_write_dropped) else $error("full buffer overwritten");

    property p_load;
        tx_load |=> tx_state_q == TX_SHIFT && tx_empty_q ##1 !serial_out_pin;
    endproperty
    a_load: assert property (p_load) else $error("holding buffer not moved");

    property p_depth;
        count_q <= RX_DEPTH;
    endproperty
    a_depth: assert property (p_depth) else $error("receive queue over two");

    property p_pop;
        (pop && !push_ok) |=> count_q == $past(count_q) - 2'h1 && rd_ptr_q != $past(rd_ptr_q);
    endproperty
    a_pop: assert property (p_pop) else $error("read did not pop");

    property p_flush;
        (!rx_en && count_q != 2'h0) |=> count_q == 2'h0;
    endproperty
    a_flush: assert property (p_flush) else $error("disable did not flush");

    property p_upper_zero;
        push_ok |-> (rx_sh_q & ~size_mask) == 9'h000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");

    property p_divisor;
        tx_state_q == TX_SHIFT |-> tx_cnt_q < (ctrl_q[CTRL_DOUBLE] ? 5'h08 : 5'h10);
    endproperty
    a_divisor: assert property (p_divisor) else $error("bit counter past divisor");

    c_frame_sent: cover property (tx_last);
    c_queue_full: cover property (push_ok ##[1:1000] count_q == RX_DEPTH);
    c_overrun: cover property (ev[EV_OVR]);
    c_irq: cover property ($rose(irq));
endmodule

// File: hdl/uart_pkg.sv
/*
 * Constants shared by the serial data buffer block: register map, field
 * positions, reset values and bit-timing divisors.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package uart_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_DOUBLE = 2;
    localparam int CTRL_SIZE_LSB = 3;
    localparam int CTRL_TX_NINTH = 6;
    localparam logic [7:0] CTRL_RESET = 8'h18;

    localparam int ST_RXC = 0;
    localparam int ST_TXE = 1;
    localparam int ST_TXC = 2;
    localparam int ST_NINTH = 3;
    localparam int ST_FE = 4;

    localparam int EV_RX = 0;
    localparam int EV_TXE = 1;
    localparam int EV_TXC = 2;
    localparam int EV_OVR = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    localparam int BAUD_W = 12;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // ------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------
    localparam logic [4:0] SPB_NORMAL = 5'h10;
    localparam logic [4:0] SPB_DOUBLE = 5'h08;
    localparam logic [2:0] SIZE_9 = 3'h7;
    localparam logic [1:0] RX_DEPTH = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hdl/baud_if.sv
/*
 * Carrier between the data buffer core and its baud generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface baud_if;
    logic [11:0] divider;
    logic tick;
    modport gen (input divider, output tick);
    modport use_tick (output divider, input tick);
endinterface

// File: hdl/uart_baud.sv
/*
 * Oversampling tick generator: one tick every divider+1 clocks.
 * Assumes the divider may change at any time; the counter recovers.
 */
`timescale 1ns/1ps
module uart_baud (
    input wire logic aclk,    // System clock
    input wire logic aresetn, // Synchronous reset, active low
    baud_if.gen bus           // Divider in, tick out
);
    logic [11:0] cnt_q;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 12'h000;
            bus.tick <= 1'b0;
        end else if (cnt_q >= bus.divider) begin
            cnt_q <= 12'h000;
            bus.tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 12'h001;
            bus.tick <= 1'b0;
        end
    end

    property p_tick_spacing;
        @(posedge aclk) disable iff (!aresetn)
        (bus.tick && bus.divider == 12'h001 && $stable(bus.divider)) |=> !bus.tick ##1 bus.tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("baud tick spacing wrong");
endmodule

// File: verification/serial_node.sv
/* Remote serial node: sends frames and decodes frames on the line.
   Assumes one start bit, nbits data LSB first, one stop bit, idle high. */
`timescale 1ns/1ps
module serial_node (
    input wire logic aclk,           // Bit timing clock
    input wire logic line_in,        // Line from the device
    output logic line_out,           // Line to the device
    input wire logic [5:0] bit_clks, // Clocks per bit
    input wire logic [3:0] nbits     // Data bits per frame
);
    logic [8:0] acc;
    logic [8:0] rx_word;
    logic rx_fe;
    int rx_count;
    initial begin
        line_out = 1'b1;
        rx_count = 0;
        rx_word = 9'h000;
        rx_fe = 1'b0;
    end
    // --------
    // Receiver
    // --------
    always begin
        @(negedge line_in);
        acc = 9'h000;
        repeat (bit_clks / 2) @(posedge aclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge aclk);
            acc[i] = line_in;
        end
        repeat (bit_clks) @(posedge aclk);
        rx_fe = !line_in;
        rx_word = acc;
        rx_count++;
    end
    // --------
    // Sender
    // --------
    task automatic send(input logic [8:0] v);
        @(posedge aclk);
        line_out <= 1'b0;
        repeat (bit_clks) @(posedge aclk);
        for (int i = 0; i < nbits; i++) begin
            line_out <= v[i];
            repeat (bit_clks) @(posedge aclk);
        end
        line_out <= 1'b1;
        repeat (bit_clks) @(posedge aclk);
    endtask
endmodule

// File: verification/uart_data_buffer_tb_top.sv
/* Self-checking bench for the serial data buffer block.
   Assumes the remote serial node model on the serial lines. */
`timescale 1ns/1ps
module uart_data_buffer_tb_top
    import uart_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic bvalid, arready, rvalid, serial_in, serial_out_pin, irq;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [5:0] bit_clks;
    logic [3:0] nbits;
    logic [7:0] q [3];
    int num_errors = 0;
    int check_count = 0;
    int n, base, bits;
    always #2 aclk = ~aclk;
    uart_data_buffer i_uart_data_buffer (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .serial_in, .serial_out_pin,
        .irq);
    serial_node i_serial_node (.aclk, .line_in(serial_out_pin), .line_out(serial_in),
        .bit_clks, .nbits);
    // --------
    // Helpers
    // --------
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic guard();
        n++;
        if (n > 3000) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            guard();
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid || !bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            guard();
            if (arready) arvalid <= 1'b0;
        end while (arvalid || !rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_rx(input int cnt);
        n = 0;
        while (i_serial_node.rx_count < cnt) begin
            @(posedge aclk);
            guard();
        end
    endtask
    function automatic logic [8:0] expect_char(input logic [8:0] v, input int w);
        return v & ((9'h001 << w) - 9'h001);
    endfunction
    function automatic logic [5:0] bit_time(input logic [4:0] spb, input logic [11:0] baud);
        return 6'(spb * (baud + 12'h001));
    endfunction
    // --------
    // Sequence
    // --------
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        bit_clks = bit_time(SPB_NORMAL, 12'h001);
        nbits = 4'h8;
        void'($urandom(61135));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd_reg(OFF_STATUS);
        check("tx empty", rd[ST_TXE], 1'b1);
        rd_reg(8'h40);
        check("unmapped read", rs, RESP_SLVERR);
        wr(8'h40, 32'h1);
        check("unmapped write", rs, RESP_SLVERR);
        wr(OFF_BAUD, 32'h1);
        wr(OFF_CTRL, 32'h1b);
        for (int k = 0; k < 3; k++) begin
            q[k] = 8'($urandom);
            wr(OFF_DATA, {24'h0, q[k]});
        end
        rd_reg(OFF_STATUS);
        check("tx full", rd[ST_TXE], 1'b0);
        wait_rx(1);
        check("tx first", i_serial_node.rx_word, q[0]);
        wait_rx(2);
        check("tx second", i_serial_node.rx_word, q[1]);
        repeat (400) @(posedge aclk);
        check("tx dropped", i_serial_node.rx_count, 2);
        wr(OFF_IRQ_STAT, 32'hf);
        for (int k = 0; k < 3; k++) i_serial_node.send({1'b0, q[k]});
        rd_reg(OFF_IRQ_STAT);
        check("overrun", rd[EV_OVR], 1'b1);
        for (int k = 0; k < 2; k++) begin
            rd_reg(OFF_DATA);
            check("rx order", rd, q[k]);
        end
        rd_reg(OFF_STATUS);
        check("rx empty", rd[ST_RXC], 1'b0);
        i_serial_node.send({1'b0, q[2]});
        rd_reg(OFF_STATUS);
        check("rx full", rd[ST_RXC], 1'b1);
        wr(OFF_CTRL, 32'h19);
        rd_reg(OFF_STATUS);
        check("rx flushed", rd[ST_RXC], 1'b0);
        wr(OFF_BAUD, 32'h0);
        bit_clks = bit_time(SPB_DOUBLE, 12'h000);
        for (int s = 0; s < 4; s++) begin
            bits = (s == 3) ? 9 : s + 5;
            nbits = 4'(bits);
            wr(OFF_CTRL, {25'h0, 1'b1, (s == 3) ? SIZE_9 : 3'(s), 3'b111});
            d = 8'($urandom);
            if (bits < 8) d[bits] = 1'b0;
            base = i_serial_node.rx_count;
            wr(OFF_DATA, {24'h0, d});
            wait_rx(base + 1);
            check("tx char", i_serial_node.rx_word, expect_char({1'b1, d}, bits));
            check("tx stop", i_serial_node.rx_fe, 1'b0);
            d = 8'($urandom);
            i_serial_node.send({1'b1, d});
            rd_reg(OFF_STATUS);
            check("ninth", rd[ST_NINTH], bits == 9);
            rd_reg(OFF_DATA);
            check("rx char", rd, expect_char({1'b1, d}, bits));
        end
        wr(OFF_IRQ_STAT, 32'hf);
        wr(OFF_IRQ_MASK, 32'h1);
        base = i_serial_node.rx_count;
        wr(OFF_DATA, 32'h55);
        wait_rx(base + 1);
        repeat (16) @(posedge aclk);
        check("irq masked", irq, 1'b0);
        i_serial_node.send(9'h0a5);
        check("irq raised", irq, 1'b1);
        rd_reg(OFF_IRQ_STAT);
        check("events", rd, 32'h7);
        wr(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge aclk);
        check("irq cleared", irq, 1'b0);
        summarize();
    end
endmodule
